// [design/soc_pkg.sv]
// constants and carrier types of the sensor output control logic
// assumes a 200 MHz system clock and a same-clock register write port
package soc_pkg;

  // timing
  localparam int CLK_MHZ      = 200;
  localparam int GLITCH_NS    = 200;
  localparam int GLITCH_CYC   = (GLITCH_NS * CLK_MHZ) / 1000;
  localparam int STRETCH_US   = 4000;
  localparam int OC_US        = 500;
  localparam int RETRY_US     = 50000;
  localparam int POR_UNIT_US  = 4000;
  localparam int OSC_HZ       = 34000;
  localparam int DUTY_STEPS   = 512;
  localparam int OSC_STEP_CYC = (CLK_MHZ * 1000000) / (OSC_HZ * DUTY_STEPS);

  // power-on delay multiples of the 4 ms unit: 8, 12, 16, 40 ms
  localparam logic [3:0] POR_MULT_0 = 4'h2;
  localparam logic [3:0] POR_MULT_1 = 4'h3;
  localparam logic [3:0] POR_MULT_2 = 4'h4;
  localparam logic [3:0] POR_MULT_3 = 4'hA;

  // register offsets
  localparam logic [5:0] ADDR_MISC     = 6'h12;
  localparam logic [5:0] ADDR_OSC      = 6'h13;
  localparam logic [5:0] ADDR_UPPER    = 6'h14;
  localparam logic [5:0] ADDR_LOWER    = 6'h15;
  localparam logic [5:0] ADDR_POLARITY = 6'h16;
  localparam logic [5:0] ADDR_STATUS   = 6'h17;
  localparam logic [5:0] ADDR_DUTY_MSB = 6'h19;
  localparam logic [5:0] ADDR_DUTY_ONE = 6'h1A;
  localparam logic [5:0] ADDR_DUTY_TWO = 6'h1B;

  // field positions
  localparam int BIT_STRETCH_EN = 1;
  localparam int WIPER_LSB      = 2;
  localparam int BIT_OSC_EN     = 0;
  localparam int BIT_OSC_FL     = 1;
  localparam int BIT_OSC_FH     = 2;
  localparam int BIT_OSC_DRIVE  = 3;
  localparam int POR_LSB        = 6;
  localparam int BIT_CMP_INV    = 0;
  localparam int BIT_STR_POL    = 1;
  localparam int BIT_D1_MSB     = 0;
  localparam int BIT_D2_MSB     = 1;
  localparam int MODE_LSB       = 2;
  localparam int BIT_NC         = 4;
  localparam int BIT_ILIM       = 5;
  localparam int CODE_W         = 6;

  localparam logic [7:0] RST_CFG = 8'h00;

  typedef enum logic [1:0] {
    SOC_HIGH_SIDE = 2'h0,
    SOC_LOW_SIDE  = 2'h1,
    SOC_PUSH_PULL = 2'h2
  } soc_mode_t;

  typedef struct packed {
    logic       en;
    logic [5:0] addr;
    logic [7:0] data;
  } soc_reg_wr_t;

  typedef struct packed {
    logic highOn;
    logic lowOn;
    logic led;
  } soc_drv_t;

endpackage

// [design/soc_sensor_output_control.sv]
// sensor output control: comparator hysteresis, pulse stretcher, driver,
// short-circuit autoretry, indicator, oscillator, duty commit, wiper code
// assumes analog comparators outside, writes from the serial link on clk_sys
`timescale 1ns/100ps

module soc_sensor_output_control #(
  parameter int STRETCH_CYC  = soc_pkg::STRETCH_US * soc_pkg::CLK_MHZ,
  parameter int OC_CYC       = soc_pkg::OC_US * soc_pkg::CLK_MHZ,
  parameter int RETRY_CYC    = soc_pkg::RETRY_US * soc_pkg::CLK_MHZ,
  parameter int POR_UNIT_CYC = soc_pkg::POR_UNIT_US * soc_pkg::CLK_MHZ
) (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  // register port from the serial link
  input  wire soc_pkg::soc_reg_wr_t regWr,
  input  wire logic [5:0]          regRdAddr,
  output logic [7:0]               regRdData,
  // analog comparator results, asynchronous
  input  wire logic                aboveUpper,
  input  wire logic                belowLower,
  input  wire logic                overCurrentLow,
  input  wire logic                overCurrentHigh,
  // analog settings
  output logic [5:0]               upperThresholdCode,
  output logic [5:0]               lowerThresholdCode,
  output logic [5:0]               wiperCode,
  output logic                     currentLimitSelect,
  // logic outputs
  output logic                     comparatorLogicOut,
  output soc_pkg::soc_drv_t        driverOut,
  output logic                     oscOut,
  output logic                     oscOeN
);
  import soc_pkg::*;

  typedef enum logic {
    FLT_RUN,
    FLT_OFF
  } soc_fault_t;

  logic [7:0]  miscReg;
  logic [7:0]  oscReg;
  logic [7:0]  upperReg;
  logic [7:0]  lowerReg;
  logic [7:0]  polarityReg;
  logic [7:0]  dutyMsbReg;
  logic [7:0]  dutyOneLowReg;
  logic [7:0]  dutyTwoLowReg;
  logic [8:0]  dutyOneAct_reg;
  logic [8:0]  dutyTwoAct_reg;
  logic [3:0]  syncA_reg;
  logic [3:0]  syncB_reg;
  logic        hyst_reg;
  logic        filt_reg;
  logic [5:0]  glitchCnt_reg;
  logic        stretch_reg;
  logic [19:0] stretchCnt_reg;
  soc_fault_t  fault_reg;
  logic [23:0] faultCnt_reg;
  logic [27:0] porCnt_reg;
  logic        porHold_reg;
  logic [3:0]  stepCnt_reg;
  logic [8:0]  phase_reg;
  logic        oscLevel_reg;
  logic        oscDrive_reg;
  logic        drvActive;
  logic        drvIn;
  logic        overCurrent;
  logic        ocNow;
  logic [8:0]  dutySel;
  logic [27:0] porLimit;
  logic        oscNext;
  logic        oscDriveNext;
  soc_mode_t   drvMode;

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      miscReg       <= RST_CFG;
      oscReg        <= RST_CFG;
      upperReg      <= RST_CFG;
      lowerReg      <= RST_CFG;
      polarityReg   <= RST_CFG;
      dutyMsbReg    <= RST_CFG;
      dutyOneLowReg <= RST_CFG;
      dutyTwoLowReg <= RST_CFG;
    end
    else if (regWr.en)
    begin
      case (regWr.addr)
        ADDR_MISC:     miscReg       <= regWr.data;
        ADDR_OSC:      oscReg        <= regWr.data;
        ADDR_UPPER:    upperReg      <= regWr.data;
        ADDR_LOWER:    lowerReg      <= regWr.data;
        ADDR_POLARITY: polarityReg   <= regWr.data;
        ADDR_DUTY_MSB: dutyMsbReg    <= regWr.data;
        ADDR_DUTY_ONE: dutyOneLowReg <= regWr.data;
        ADDR_DUTY_TWO: dutyTwoLowReg <= regWr.data;
        default:       ;
      endcase
    end
  end

  // low bytes wait in their registers until the msb register is written
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dutyOneAct_reg <= {1'b0, RST_CFG};
      dutyTwoAct_reg <= {1'b0, RST_CFG};
    end
    else if (regWr.en && regWr.addr == ADDR_DUTY_MSB)
    begin
      dutyOneAct_reg <= {regWr.data[BIT_D1_MSB], dutyOneLowReg};
      dutyTwoAct_reg <= {regWr.data[BIT_D2_MSB], dutyTwoLowReg};
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      regRdData <= 8'h00;
    else
    begin
      case (regRdAddr)
        ADDR_MISC:     regRdData <= miscReg;
        ADDR_OSC:      regRdData <= oscReg;
        ADDR_UPPER:    regRdData <= {2'h0, upperReg[CODE_W-1:0]};
        ADDR_LOWER:    regRdData <= {2'h0, lowerReg[CODE_W-1:0]};
        ADDR_POLARITY: regRdData <= polarityReg;
        ADDR_STATUS:   regRdData <= {4'h0, porHold_reg, fault_reg == FLT_OFF,
                                     drvActive, comparatorLogicOut};
        ADDR_DUTY_MSB: regRdData <= dutyMsbReg;
        ADDR_DUTY_ONE: regRdData <= dutyOneLowReg;
        ADDR_DUTY_TWO: regRdData <= dutyTwoLowReg;
        default:       regRdData <= 8'h00;
      endcase
    end
  end

  // codes for the reference DACs, wiper and current limit
  assign upperThresholdCode = upperReg[CODE_W-1:0];
  assign lowerThresholdCode = lowerReg[CODE_W-1:0];
  assign wiperCode          = miscReg[WIPER_LSB +: CODE_W];
  assign currentLimitSelect = dutyMsbReg[BIT_ILIM];

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      syncA_reg <= 4'h0;
      syncB_reg <= 4'h0;
    end
    else
    begin
      syncA_reg <= {overCurrentHigh, overCurrentLow, belowLower, aboveUpper};
      syncB_reg <= syncA_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // comparator hysteresis

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      hyst_reg <= 1'b0;
    else if (syncB_reg[0])
      hyst_reg <= 1'b1;
    else if (syncB_reg[1])
      hyst_reg <= 1'b0;
  end

  // taken from the hysteresis state, ahead of the stretcher
  assign comparatorLogicOut = hyst_reg ^ polarityReg[BIT_CMP_INV];

  ////////////////////////////////////////////////////////////////////////
  // glitch filter and pulse stretcher

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      filt_reg      <= 1'b0;
      glitchCnt_reg <= 6'h00;
    end
    else if (hyst_reg == filt_reg)
      glitchCnt_reg <= 6'h00;
    else if (glitchCnt_reg == 6'(GLITCH_CYC - 1))
    begin
      filt_reg      <= hyst_reg;
      glitchCnt_reg <= 6'h00;
    end
    else
      glitchCnt_reg <= glitchCnt_reg + 6'h01;
  end

  // stretch_reg holds the pulse active high; drvIn puts back the stretched polarity
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stretch_reg    <= 1'b0;
      stretchCnt_reg <= 20'h00000;
    end
    else if ((filt_reg ^ polarityReg[BIT_STR_POL]) && !stretch_reg)
    begin
      stretch_reg    <= 1'b1;
      stretchCnt_reg <= 20'(STRETCH_CYC - 1);
    end
    else if (stretchCnt_reg != 20'h00000)
      stretchCnt_reg <= stretchCnt_reg - 20'h00001;
    else if (!(filt_reg ^ polarityReg[BIT_STR_POL]))
      stretch_reg <= 1'b0;
  end

  assign drvIn = miscReg[BIT_STRETCH_EN] ?
                 (stretch_reg ^ polarityReg[BIT_STR_POL]) : hyst_reg;

  ////////////////////////////////////////////////////////////////////////
  // short-circuit autoretry

  assign overCurrent = currentLimitSelect ? syncB_reg[3] : syncB_reg[2];
  assign ocNow       = overCurrent && fault_reg == FLT_RUN;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fault_reg    <= FLT_RUN;
      faultCnt_reg <= 24'h000000;
    end
    else
    begin
      case (fault_reg)
        FLT_RUN:
        begin
          if (!ocNow)
            faultCnt_reg <= 24'h000000;
          else if (faultCnt_reg == 24'(OC_CYC - 1))
          begin
            fault_reg    <= FLT_OFF;
            faultCnt_reg <= 24'h000000;
          end
          else
            faultCnt_reg <= faultCnt_reg + 24'h000001;
        end
        FLT_OFF:
        begin
          if (faultCnt_reg == 24'(RETRY_CYC - 1))
          begin
            fault_reg    <= FLT_RUN;
            faultCnt_reg <= 24'h000000;
          end
          else
            faultCnt_reg <= faultCnt_reg + 24'h000001;
        end
        default:
        begin
          fault_reg    <= FLT_RUN;
          faultCnt_reg <= 24'h000000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-on indicator hold

  always_comb
  begin
    case (oscReg[POR_LSB +: 2])
      2'h0:    porLimit = 28'(POR_UNIT_CYC) * 28'(POR_MULT_0);
      2'h1:    porLimit = 28'(POR_UNIT_CYC) * 28'(POR_MULT_1);
      2'h2:    porLimit = 28'(POR_UNIT_CYC) * 28'(POR_MULT_2);
      default: porLimit = 28'(POR_UNIT_CYC) * 28'(POR_MULT_3);
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      porCnt_reg  <= 28'h0000000;
      porHold_reg <= 1'b1;
    end
    else if (porHold_reg)
    begin
      if (porCnt_reg >= porLimit - 28'h0000001)
        porHold_reg <= 1'b0;
      else
        porCnt_reg <= porCnt_reg + 28'h0000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // driver and indicator

  assign drvMode   = soc_mode_t'(dutyMsbReg[MODE_LSB +: 2]);
  assign drvActive = (drvIn ^ dutyMsbReg[BIT_NC]) && fault_reg == FLT_RUN;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      driverOut <= '0;
    else
    begin
      driverOut.led <= drvActive && !porHold_reg;
      case (drvMode)
        SOC_HIGH_SIDE:
        begin
          driverOut.highOn <= drvActive;
          driverOut.lowOn  <= 1'b0;
        end
        SOC_LOW_SIDE:
        begin
          driverOut.highOn <= 1'b0;
          driverOut.lowOn  <= drvActive;
        end
        default:
        begin
          driverOut.highOn <= drvActive;
          driverOut.lowOn  <= !drvActive && fault_reg == FLT_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // oscillator

  assign dutySel = hyst_reg ? dutyOneAct_reg : dutyTwoAct_reg;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stepCnt_reg <= 4'h0;
      phase_reg   <= 9'h000;
    end
    else if (stepCnt_reg == 4'(OSC_STEP_CYC - 1))
    begin
      stepCnt_reg <= 4'h0;
      phase_reg   <= phase_reg + 9'h001;
    end
    else
      stepCnt_reg <= stepCnt_reg + 4'h1;
  end

  always_comb
  begin
    if (oscReg[BIT_OSC_FH])
      oscNext = 1'b1;
    else if (oscReg[BIT_OSC_FL])
      oscNext = 1'b0;
    else
      oscNext = phase_reg < dutySel;
    if (!oscReg[BIT_OSC_EN])
      oscDriveNext = 1'b0;
    else if (oscReg[BIT_OSC_DRIVE])
      oscDriveNext = 1'b1;
    else
      oscDriveNext = !oscNext;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      oscLevel_reg <= 1'b0;
      oscDrive_reg <= 1'b0;
    end
    else
    begin
      oscLevel_reg <= oscNext && oscReg[BIT_OSC_EN];
      oscDrive_reg <= oscDriveNext;
    end
  end

  assign oscOut = oscLevel_reg;
  assign oscOeN = !oscDrive_reg;

endmodule

// [test/soc_sense_model.sv]
// sensing circuit and load facing the sensor output control
// assumes levels on the 63-step threshold scale and load current in mA
`timescale 1ns/100ps

module soc_sense_model (
  // programmed thresholds
  input  wire logic [5:0] upperCode,
  input  wire logic [5:0] lowerCode,
  // sense level and load current
  input  wire logic [5:0] senseLvl,
  input  wire logic [7:0] loadMa,
  // comparator results
  output logic            aboveUpper,
  output logic            belowLower,
  output logic            overCurrentLow,
  output logic            overCurrentHigh
);
  // level and code share the code/63 scale
  assign aboveUpper      = senseLvl > upperCode;
  assign belowLower      = senseLvl < lowerCode;
  assign overCurrentLow  = loadMa > 8'h64;
  assign overCurrentHigh = loadMa > 8'hC8;
endmodule

// [test/soc_sensor_output_control_monitor.sv]
// port checker for the sensor output control
// assumes the top module ports only, one clock domain
`timescale 1ns/100ps

module soc_sensor_output_control_monitor
  import soc_pkg::*;
#(
  parameter int OC_CYC       = 100000,
  parameter int POR_UNIT_CYC = 800000
) (
  // clock and reset
  input wire logic                 clk_sys,
  input wire logic                 sys_rst,
  // register port
  input wire soc_pkg::soc_reg_wr_t regWr,
  input wire logic [5:0]           regRdAddr,
  input wire logic [7:0]           regRdData,
  // sensing inputs
  input wire logic                 aboveUpper,
  input wire logic                 belowLower,
  input wire logic                 overCurrentLow,
  input wire logic                 overCurrentHigh,
  // outputs
  input wire logic [5:0]           upperThresholdCode,
  input wire logic                 currentLimitSelect,
  input wire logic                 comparatorLogicOut,
  input wire soc_pkg::soc_drv_t    driverOut,
  input wire logic                 oscOut,
  input wire logic                 oscOeN
);
  logic       invReg;
  logic [3:0] oscCfg;
  int         ocRun;
  int         porCnt;
  logic       ocSel;
  logic       hystSeen;

  assign ocSel    = currentLimitSelect ? overCurrentHigh : overCurrentLow;
  assign hystSeen = comparatorLogicOut ^ invReg;

  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      invReg <= 1'b0;
    else if (regWr.en && regWr.addr == ADDR_POLARITY)
      invReg <= regWr.data[BIT_CMP_INV];

  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      oscCfg <= 4'h0;
    else if (regWr.en && regWr.addr == ADDR_OSC)
      oscCfg <= regWr.data[3:0];

  // driver-on cycles under a continuous overcurrent
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      ocRun <= 0;
    else if (ocSel && (driverOut.highOn || driverOut.lowOn))
      ocRun <= ocRun + 1;
    else
      ocRun <= 0;

  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      porCnt <= 0;
    else if (porCnt < 2 * POR_UNIT_CYC)
      porCnt <= porCnt + 1;

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_above;
    (aboveUpper && !belowLower)[*3];
  endsequence
  sequence s_below;
    (belowLower && !aboveUpper)[*3];
  endsequence
  sequence s_between;
    (!aboveUpper && !belowLower)[*4];
  endsequence

  a_cmp_rise: assert property (s_above |=> comparatorLogicOut == !invReg)
    else $error("comparator did not switch high");
  a_cmp_fall: assert property (s_below |=> comparatorLogicOut == invReg)
    else $error("comparator did not switch low");
  a_cmp_hold: assert property (s_between |=> $stable(hystSeen))
    else $error("comparator changed between thresholds");
  a_osc_off: assert property (!oscCfg[BIT_OSC_EN] [*2] |=> oscOeN && !oscOut)
    else $error("oscillator active while disabled");
  a_force_high: assert property ((oscCfg == 4'hD) [*2] |=> oscOut && !oscOeN)
    else $error("forced high not driven");
  a_force_low: assert property ((oscCfg[2:0] == 3'h3) [*2] |=> !oscOut && !oscOeN)
    else $error("forced low not driven");
  a_upper_readback: assert property (regRdAddr == ADDR_UPPER
    |=> regRdData[5:0] == $past(upperThresholdCode))
    else $error("upper code readback differs");
  a_ilim_follow: assert property (regWr.en && regWr.addr == ADDR_DUTY_MSB
    |=> currentLimitSelect == $past(regWr.data[BIT_ILIM]))
    else $error("limit select not updated");
  a_oc_limit: assert property (ocRun <= OC_CYC + 8)
    else $error("driver stayed on under overcurrent");
  a_led_por: assert property (porCnt < 2 * POR_UNIT_CYC - 2 |-> !driverOut.led)
    else $error("indicator on during power-on delay");
endmodule

bind soc_sensor_output_control soc_sensor_output_control_monitor #(
  .OC_CYC(OC_CYC), .POR_UNIT_CYC(POR_UNIT_CYC)) u_mon (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .regWr(regWr), .regRdAddr(regRdAddr),
  .regRdData(regRdData), .aboveUpper(aboveUpper), .belowLower(belowLower),
  .overCurrentLow(overCurrentLow), .overCurrentHigh(overCurrentHigh),
  .upperThresholdCode(upperThresholdCode), .currentLimitSelect(currentLimitSelect),
  .comparatorLogicOut(comparatorLogicOut), .driverOut(driverOut), .oscOut(oscOut),
  .oscOeN(oscOeN));

// [test/soc_sensor_output_control_tb.sv]
// self-checking bench for the sensor output control
// assumes the sense model as far side and shortened time parameters
`timescale 1ns/100ps

module soc_sensor_output_control_tb;
  import soc_pkg::*;
  localparam int SC = 100, OC = 20, RT = 50, PU = 10;
  localparam int PER = DUTY_STEPS * OSC_STEP_CYC;
  localparam logic [5:0] HI = 6'h3F, LO = 6'h00;
  localparam logic [5:0] AD [7] = '{ADDR_MISC, ADDR_OSC, ADDR_UPPER, ADDR_LOWER,
    ADDR_POLARITY, ADDR_DUTY_ONE, ADDR_DUTY_TWO};
  logic clk_sys, sys_rst, aboveUpper, belowLower, overCurrentLow, overCurrentHigh;
  logic currentLimitSelect, comparatorLogicOut, oscOut, oscOeN;
  logic [5:0] regRdAddr, upperThresholdCode, lowerThresholdCode, wiperCode, senseLvl;
  logic [7:0] regRdData, loadMa;
  soc_reg_wr_t regWr;
  soc_drv_t driverOut;
  int errCount = 0, nChecks = 0, cyc = 0;
  logic [31:0] seed = 32'h32EEA5E2;

  soc_sensor_output_control #(.STRETCH_CYC(SC), .OC_CYC(OC), .RETRY_CYC(RT),
    .POR_UNIT_CYC(PU)) u_dut (.clk_sys, .sys_rst, .regWr, .regRdAddr, .regRdData,
    .aboveUpper, .belowLower, .overCurrentLow, .overCurrentHigh, .upperThresholdCode,
    .lowerThresholdCode, .wiperCode, .currentLimitSelect, .comparatorLogicOut,
    .driverOut, .oscOut, .oscOeN);
  soc_sense_model u_model (.upperCode(upperThresholdCode), .lowerCode(lowerThresholdCode),
    .senseLvl, .loadMa, .aboveUpper, .belowLower, .overCurrentLow, .overCurrentHigh);

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      errCount++;
      endOfTest();
    end
  end

  task endOfTest;
    if (errCount == 0 && nChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    nChecks++;
    if (seen !== exp)
    begin
      errCount++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [2:0] drvExp(input logic [1:0] m, input logic nc, a);
    logic act;
    act = a ^ nc;
    if (m == SOC_HIGH_SIDE)
      return {act, 1'b0, act};
    if (m == SOC_LOW_SIDE)
      return {1'b0, act, act};
    return {act, !act, act};
  endfunction

  function automatic logic near(input int h, c);
    return h >= (c - 1) * OSC_STEP_CYC && h <= (c + 1) * OSC_STEP_CYC;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regWr <= '{1'b1, a, v};
    @(posedge clk_sys);
    regWr.en <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    regRdAddr <= a;
    tick(2);
    v = regRdData;
  endtask

  task automatic pulse(input int w, input logic [5:0] b, p, output int nd, nq);
    nd = 0;
    nq = 0;
    for (int i = 0; i < 300; i++)
    begin
      @(posedge clk_sys);
      if (i == 0)
        senseLvl <= p;
      if (i == w)
        senseLvl <= b;
      #1;
      nd += driverOut.highOn;
      nq += comparatorLogicOut;
    end
  endtask

  task automatic runLen(input logic v, output int n);
    n = 0;
    while (driverOut.highOn === v && n < 400)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask

  task automatic duty(output int h);
    h = 0;
    tick(PER);
    repeat (PER)
    begin
      @(posedge clk_sys);
      #1;
      h += oscOut;
    end
  endtask

  initial
  begin
    logic [7:0] d;
    logic [5:0] up, lo;
    logic [8:0] d1, d2;
    logic [31:0] r;
    int a, b;
    sys_rst = 1'b1;
    regWr = '0;
    regRdAddr = '0;
    senseLvl = LO;
    loadMa = 8'h00;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    wr(ADDR_DUTY_MSB, 8'h10);
    tick(6);
    chk("led hold", driverOut.led, 1'b0);
    tick(20);
    chk("led after", driverOut.led, 1'b1);
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, d);
    chk("status", d, 8'h02);
    for (int i = 0; i < 7; i++)
    begin
      rd(AD[i], d);
      chk("reset value", d, 8'h00);
    end
    wr(6'h3F, 8'hA5);
    rd(6'h3F, d);
    chk("unmapped", d, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      r = xs();
      lo = 6'h01 + 6'(r[3:0]);
      up = lo + 6'h04 + 6'(r[7:4]);
      wr(ADDR_UPPER, {2'h0, up});
      wr(ADDR_LOWER, {2'h0, lo});
      wr(ADDR_MISC, {r[13:8], 2'h0});
      rd(ADDR_MISC, d);
      chk("misc", d, {r[13:8], 2'h0});
      chk("upper", upperThresholdCode, up);
      chk("wiper", wiperCode, r[13:8]);
      chk("lower", lowerThresholdCode, lo);
      rd(ADDR_UPPER, d);
      chk("upper rd", d, {2'h0, up});
    end
    for (int inv = 0; inv < 2; inv++)
    begin
      wr(ADDR_POLARITY, 8'(inv));
      for (int s = 0; s < 4; s++)
      begin
        senseLvl <= s == 0 ? HI : s == 2 ? LO : lo + 6'h01;
        tick(6);
        chk("cmp", comparatorLogicOut, 1'(s < 2) ^ 1'(inv));
      end
    end
    wr(ADDR_POLARITY, 8'h00);
    wr(ADDR_LOWER, {2'h0, up});
    senseLvl <= up + 6'h01;
    tick(6);
    chk("single up", comparatorLogicOut, 1'b1);
    senseLvl <= up - 6'h01;
    tick(6);
    chk("single dn", comparatorLogicOut, 1'b0);
    for (int m = 0; m < 3; m++)
      for (int k = 0; k < 4; k++)
      begin
        wr(ADDR_DUTY_MSB, {3'h0, 1'(k), 2'(m), 2'h0});
        senseLvl <= k[1] ? HI : LO;
        tick(8);
        chk("driver", driverOut, drvExp(2'(m), 1'(k), k[1]));
      end
    wr(ADDR_DUTY_MSB, 8'h00);
    wr(ADDR_MISC, 8'h02);
    senseLvl <= LO;
    tick(60);
    pulse(60, LO, HI, a, b);
    chk("stretch", a >= SC && a <= SC + 8, 1'b1);
    chk("cmp raw", b, 60);
    pulse(20, LO, HI, a, b);
    chk("glitch", a, 0);
    wr(ADDR_POLARITY, 8'h02);
    senseLvl <= HI;
    // polarity flip starts a stretch of its own; let it run out
    tick(160);
    pulse(60, HI, LO, a, b);
    chk("neg stretch", 300 - a >= SC && 300 - a <= SC + 8, 1'b1);
    wr(ADDR_MISC, 8'h00);
    tick(60);
    loadMa <= 8'h96;
    runLen(1'b1, a);
    chk("oc trip", a >= OC && a <= OC + 8, 1'b1);
    runLen(1'b0, a);
    chk("retry off", a >= RT && a <= RT + 3, 1'b1);
    runLen(1'b1, a);
    chk("retrip", a >= OC && a <= OC + 4, 1'b1);
    runLen(1'b0, a);
    wr(ADDR_DUTY_MSB, 8'h20);
    runLen(1'b1, a);
    chk("high limit", a, 400);
    loadMa <= 8'h00;
    wr(ADDR_DUTY_MSB, 8'h00);
    runLen(1'b1, a);
    chk("resume", a, 400);
    wr(ADDR_OSC, 8'h0D);
    tick(4);
    chk("force hi", {oscOut, oscOeN}, 2'h2);
    wr(ADDR_OSC, 8'h03);
    tick(4);
    chk("force lo", {oscOut, oscOeN}, 2'h0);
    wr(ADDR_OSC, 8'h05);
    tick(4);
    chk("od release", oscOeN, 1'b1);
    wr(ADDR_OSC, 8'h00);
    tick(4);
    chk("osc off", {oscOut, oscOeN}, 2'h1);
    d1 = 9'(xs());
    d2 = 9'(xs());
    wr(ADDR_DUTY_ONE, d1[7:0]);
    wr(ADDR_DUTY_TWO, d2[7:0]);
    wr(ADDR_DUTY_MSB, {6'h00, d2[8], d1[8]});
    wr(ADDR_OSC, 8'h09);
    duty(a);
    chk("duty one", near(a, d1), 1'b1);
    senseLvl <= LO;
    duty(a);
    chk("duty two", near(a, d2), 1'b1);
    senseLvl <= HI;
    wr(ADDR_DUTY_ONE, ~d1[7:0]);
    duty(a);
    chk("no commit", near(a, d1), 1'b1);
    wr(ADDR_DUTY_MSB, {6'h00, d2[8], d1[8]});
    duty(a);
    chk("commit", near(a, {d1[8], ~d1[7:0]}), 1'b1);
    endOfTest();
  end
endmodule
